// ==== hw/cswt_pkg.sv ====
// Constants and types shared by the cyclic sense / cyclic wake timer block.
// Assumes a 100 MHz system clock; only the filter time is converted to cycles here, periods and on-times in cswt_timer.
`default_nettype none

package cswt_pkg;

    // ==========================================================
    // Clock
    localparam int CLK_MHZ = 100;

    // ==========================================================
    // Device modes as seen from the mode controller
    typedef enum logic [2:0] {
        CSWT_MODE_INIT,
        CSWT_MODE_NORMAL,
        CSWT_MODE_STOP,
        CSWT_MODE_SLEEP,
        CSWT_MODE_RESTART,
        CSWT_MODE_FAILSAFE
    } cswt_mode_t;

    // ==========================================================
    // Period codes: 10/20/50/100/200 ms, 1 s, 2 s
    localparam int PER_W = 3;
    localparam int PER_MS_10 = 10;
    localparam int PER_MS_20 = 20;
    localparam int PER_MS_50 = 50;
    localparam int PER_MS_100 = 100;
    localparam int PER_MS_200 = 200;
    localparam int PER_MS_1000 = 1000;
    localparam int PER_MS_2000 = 2000;

    // ==========================================================
    // On-time codes: 0.1/0.3/1/10/20 ms, off-low, off-high
    localparam int ON_W = 3;
    localparam logic [ON_W-1:0] ON_OFF_LOW = 3'h0;
    localparam logic [ON_W-1:0] ON_US_100_C = 3'h1;
    localparam logic [ON_W-1:0] ON_US_300_C = 3'h2;
    localparam logic [ON_W-1:0] ON_US_1000_C = 3'h3;
    localparam logic [ON_W-1:0] ON_US_10000_C = 3'h4;
    localparam logic [ON_W-1:0] ON_US_20000_C = 3'h5;
    localparam logic [ON_W-1:0] ON_OFF_HIGH = 3'h6;
    localparam int ON_US_100 = 100;
    localparam int ON_US_300 = 300;
    localparam int ON_US_1000 = 1000;
    localparam int ON_US_10000 = 10000;
    localparam int ON_US_20000 = 20000;

    // ==========================================================
    // Settling filter after on-time, 16 us
    localparam int FILT_US = 16;
    localparam int FILT_CYC = FILT_US * CLK_MHZ;

    // Counter width for the longest period (2 s = 200e6 cycles)
    localparam int CNT_W = 28;
    localparam int NUM_WK = 3;
    localparam int NUM_HS = 4;
    localparam int NUM_TMR = 2;

    // Map-field encoding: 0 = none, 1 = timer 1, 2 = timer 2
    localparam logic [1:0] MAP_NONE = 2'h0;
    localparam logic [1:0] MAP_T1 = 2'h1;
    localparam logic [1:0] MAP_T2 = 2'h2;

endpackage : cswt_pkg

`default_nettype wire

// ==== hw/cswt_timer.sv ====
// One internal wake timer: period counter with an on-time window.
// Assumes the period/on-time codes are held stable by the caller between writes.
`default_nettype none

module cswt_timer
    import cswt_pkg::*;
#(
    parameter int PERIOD_SCALE = 1000 * 1000 * CLK_MHZ,
    parameter int ON_SCALE = CLK_MHZ
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Configuration
    input wire logic [cswt_pkg::PER_W-1:0] i_period,
    input wire logic [cswt_pkg::ON_W-1:0] i_on_time,
    // Status
    output logic o_running,
    output logic o_on,
    output logic o_on_start,
    output logic o_on_end,
    output logic o_first
);
    import cswt_pkg::*;

    logic [CNT_W-1:0] cnt_reg;
    logic run_reg;
    logic first_reg;
    logic [CNT_W-1:0] per_cyc;
    logic [CNT_W-1:0] on_cyc;
    logic on_active;

    // Period lookup in cycles; scale split first so 2 s stays inside int range
    // seven period codes
    function automatic logic [CNT_W-1:0] per_to_cyc(input logic [PER_W-1:0] code);
        int ms;
        ms = PER_MS_10;
        unique case (code)
            3'h0: ms = PER_MS_10;
            3'h1: ms = PER_MS_20;
            3'h2: ms = PER_MS_50;
            3'h3: ms = PER_MS_100;
            3'h4: ms = PER_MS_200;
            3'h5: ms = PER_MS_1000;
            default: ms = PER_MS_2000;
        endcase
        return CNT_W'(ms * (PERIOD_SCALE / 1000));
    endfunction

    // On-time lookup in cycles; off codes give zero
    // five on-times, two off
    function automatic logic [CNT_W-1:0] on_to_cyc(input logic [ON_W-1:0] code);
        int us;
        us = 0;
        unique case (code)
            ON_US_100_C: us = ON_US_100;
            ON_US_300_C: us = ON_US_300;
            ON_US_1000_C: us = ON_US_1000;
            ON_US_10000_C: us = ON_US_10000;
            ON_US_20000_C: us = ON_US_20000;
            default: us = 0;
        endcase
        return CNT_W'(us * ON_SCALE);
    endfunction

    assign per_cyc = per_to_cyc(i_period);
    assign on_cyc = on_to_cyc(i_on_time);
    assign on_active = (on_cyc != '0);

    // Free-running period counter, restarted when the on-time is switched on
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
            first_reg <= 1'b0;
        end else begin
            run_reg <= on_active;
            if (!on_active) begin
                cnt_reg <= '0;
                first_reg <= 1'b0;
            end else if (!run_reg) begin
                cnt_reg <= '0;
                first_reg <= 1'b1;
            end else if (cnt_reg >= per_cyc - 1'b1) begin
                cnt_reg <= '0;
                first_reg <= 1'b0;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    assign o_running = run_reg;
    assign o_on = run_reg && (cnt_reg < on_cyc);
    assign o_on_start = run_reg && (cnt_reg == '0);
    assign o_on_end = run_reg && (cnt_reg == on_cyc);
    assign o_first = first_reg;

endmodule : cswt_timer

`default_nettype wire

// ==== hw/cswt_wake_chan.sv ====
// One wake input channel: sample at on-time end, settle filter, compare.
// Assumes the pin input is already synchronised to i_clk.
`default_nettype none

module cswt_wake_chan
    import cswt_pkg::*;
#(
    parameter int FILT_CYCLES = cswt_pkg::FILT_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Sense control
    input wire logic i_pin,
    input wire logic i_armed,
    input wire logic i_on_end,
    // Results
    output logic o_sample_vld,
    output logic o_level,
    output logic o_wake
);
    import cswt_pkg::*;

    logic [15:0] fcnt_reg;
    logic filt_reg;
    logic lvl_reg;
    logic ref_reg;
    logic ref_vld_reg;
    logic done;

    assign done = filt_reg && (fcnt_reg == 16'(FILT_CYCLES - 1));

    // Filter window opened at on-time end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            fcnt_reg <= '0;
            filt_reg <= 1'b0;
            lvl_reg <= 1'b0;
        end else if (!i_armed) begin
            filt_reg <= 1'b0;
            fcnt_reg <= '0;
        end else if (i_on_end) begin
            filt_reg <= 1'b1;
            fcnt_reg <= '0;
            lvl_reg <= i_pin;
        end else if (filt_reg) begin
            if (i_pin != lvl_reg || done) begin
                filt_reg <= 1'b0;
            end
            fcnt_reg <= fcnt_reg + 16'h1;
        end
    end

    // Reference from previous cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ref_reg <= 1'b0;
            ref_vld_reg <= 1'b0;
        end else if (!i_armed) begin
            ref_vld_reg <= 1'b0;
        end else if (done && i_pin == lvl_reg) begin
            ref_reg <= lvl_reg;
            ref_vld_reg <= 1'b1;
        end
    end

    assign o_sample_vld = done && (i_pin == lvl_reg);
    assign o_level = lvl_reg;
    assign o_wake = o_sample_vld && ref_vld_reg && (lvl_reg != ref_reg);

endmodule : cswt_wake_chan

`default_nettype wire

// ==== hw/cswt_top.sv ====
// Cyclic sense and cyclic wake timers: two timers, four high-side outputs,
// three sensed wake inputs. Mode, faults and configuration come as ports from
// the surrounding device; the mode controller acts on the wake request.
`default_nettype none

module cswt_top
    import cswt_pkg::*;
#(
    parameter int PERIOD_SCALE = 1000 * 1000 * cswt_pkg::CLK_MHZ,
    parameter int ON_SCALE = cswt_pkg::CLK_MHZ,
    parameter int FILT_CYCLES = cswt_pkg::FILT_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Device mode and driver faults
    input wire cswt_pkg::cswt_mode_t i_mode,
    input wire logic [cswt_pkg::NUM_HS-1:0] i_hs_fault,
    // Timer configuration
    input wire logic [cswt_pkg::PER_W-1:0] i_first_timer_period,
    input wire logic [cswt_pkg::ON_W-1:0] i_first_timer_on,
    input wire logic [cswt_pkg::PER_W-1:0] i_second_timer_period,
    input wire logic [cswt_pkg::ON_W-1:0] i_second_timer_on,
    input wire logic [1:0] i_timer_wake_en,
    // Driver mapping, two bits per driver
    input wire logic [2*cswt_pkg::NUM_HS-1:0] i_high_side_map,
    // Wake input configuration: sensing timer select per pin
    input wire logic [2*cswt_pkg::NUM_WK-1:0] i_wake_sense_sel,
    // Flag clear strobe from the controller
    input wire logic [cswt_pkg::NUM_WK-1:0] i_wake_flag_clr,
    input wire logic [1:0] i_timer_flag_clr,
    // Wake pins
    input wire logic [cswt_pkg::NUM_WK-1:0] i_wake_input_pin,
    // Outputs
    output logic [cswt_pkg::NUM_HS-1:0] o_high_side_driver,
    output logic [cswt_pkg::NUM_WK-1:0] o_wake_flags,
    output logic [1:0] o_timer_flags,
    output logic [cswt_pkg::NUM_WK-1:0] o_wake_level_status,
    output logic [cswt_pkg::NUM_WK-1:0] o_static_sense,
    output logic o_int_req,
    output logic o_wake_req,
    output logic o_spi_fail
);
    import cswt_pkg::*;

    // ==========================================================
    // Pin synchronisers
    logic [NUM_WK-1:0] pin_s1_reg;
    logic [NUM_WK-1:0] pin_s2_reg;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end else begin
            pin_s1_reg <= i_wake_input_pin;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // ==========================================================
    // Timers
    logic [NUM_TMR-1:0] t_run;
    logic [NUM_TMR-1:0] t_on;
    logic [NUM_TMR-1:0] t_start;
    logic [NUM_TMR-1:0] t_end;
    logic [NUM_TMR-1:0] t_first;
    logic [ON_W-1:0] on_code [NUM_TMR];
    logic [PER_W-1:0] per_code [NUM_TMR];

    assign on_code[0] = i_first_timer_on;
    assign on_code[1] = i_second_timer_on;
    assign per_code[0] = i_first_timer_period;
    assign per_code[1] = i_second_timer_period;

    // Timers ignore driver faults, so they keep counting
    // timers unaffected by faults
    for (genvar t = 0; t < NUM_TMR; t++) begin : g_tmr
        cswt_timer #(
            .PERIOD_SCALE(PERIOD_SCALE),
            .ON_SCALE(ON_SCALE)
        ) u_tmr (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_period(per_code[t]),
            .i_on_time(on_code[t]),
            .o_running(t_run[t]),
            .o_on(t_on[t]),
            .o_on_start(t_start[t]),
            .o_on_end(t_end[t]),
            .o_first(t_first[t])
        );
    end

    // Timer index from a map/select field; none gives no timer
    function automatic logic sel_hit(input logic [1:0] f, output logic idx);
        idx = (f == MAP_T2);
        return (f == MAP_T1) || (f == MAP_T2);
    endfunction

    // Period in microseconds, for the on-time sanity check
    function automatic int per_us(input logic [PER_W-1:0] c);
        unique case (c)
            3'h0: per_us = PER_MS_10 * 1000;
            3'h1: per_us = PER_MS_20 * 1000;
            3'h2: per_us = PER_MS_50 * 1000;
            3'h3: per_us = PER_MS_100 * 1000;
            3'h4: per_us = PER_MS_200 * 1000;
            3'h5: per_us = PER_MS_1000 * 1000;
            default: per_us = PER_MS_2000 * 1000;
        endcase
    endfunction

    function automatic int on_us(input logic [ON_W-1:0] c);
        unique case (c)
            ON_US_100_C: on_us = ON_US_100;
            ON_US_300_C: on_us = ON_US_300;
            ON_US_1000_C: on_us = ON_US_1000;
            ON_US_10000_C: on_us = ON_US_10000;
            ON_US_20000_C: on_us = ON_US_20000;
            default: on_us = 0;
        endcase
    endfunction

    // ==========================================================
    // High-side drivers
    logic fail_safe;
    logic fault_mode;
    logic [NUM_HS-1:0] hs_kill_reg;

    assign fail_safe = (i_mode == CSWT_MODE_FAILSAFE);
    assign fault_mode = (i_mode == CSWT_MODE_NORMAL) || (i_mode == CSWT_MODE_STOP) ||
                        (i_mode == CSWT_MODE_SLEEP);

    // Latched fault shutdown; a driver stays off until its map is cleared
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            hs_kill_reg <= '0;
        end else begin
            for (int h = 0; h < NUM_HS; h++) begin
                if (fault_mode && i_hs_fault[h]) begin
                    hs_kill_reg[h] <= 1'b1;
                end else if (i_high_side_map[2*h +: 2] == MAP_NONE) begin
                    hs_kill_reg[h] <= 1'b0;
                end
            end
        end
    end

    // Driver follows its timer's on-time; off codes set the idle level
    always_ff @(posedge i_clk or posedge i_rst) begin
        logic hit;
        logic idx;
        if (i_rst) begin
            o_high_side_driver <= '0;
        end else begin
            for (int h = 0; h < NUM_HS; h++) begin
                hit = sel_hit(i_high_side_map[2*h +: 2], idx);
                if (fail_safe || hs_kill_reg[h] || !hit) begin
                    o_high_side_driver[h] <= 1'b0;
                end else if (t_run[idx]) begin
                    o_high_side_driver[h] <= t_on[idx];
                end else begin
                    o_high_side_driver[h] <= (on_code[idx] == ON_OFF_HIGH);
                end
            end
        end
    end

    // ==========================================================
    // Wake channels
    logic [NUM_WK-1:0] ch_armed;
    logic [NUM_WK-1:0] ch_end;
    logic [NUM_WK-1:0] ch_vld;
    logic [NUM_WK-1:0] ch_lvl;
    logic [NUM_WK-1:0] ch_wake;

    always_comb begin
        logic idx;
        logic hit;
        idx = 1'b0;
        hit = 1'b0;
        for (int w = 0; w < NUM_WK; w++) begin
            hit = sel_hit(i_wake_sense_sel[2*w +: 2], idx);
            ch_armed[w] = hit && t_run[idx] && !fail_safe;
            ch_end[w] = hit && t_end[idx];
        end
    end

    for (genvar w = 0; w < NUM_WK; w++) begin : g_wk
        cswt_wake_chan #(
            .FILT_CYCLES(FILT_CYCLES)
        ) u_ch (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_pin(pin_s2_reg[w]),
            .i_armed(ch_armed[w]),
            .i_on_end(ch_end[w]),
            .o_sample_vld(ch_vld[w]),
            .o_level(ch_lvl[w]),
            .o_wake(ch_wake[w])
        );
    end

    // Static sense flag: input not under cyclic sensing or in fail-safe
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_static_sense <= '1;
        end else begin
            o_static_sense <= ~ch_armed;
        end
    end

    // Level status: sampled levels while sensing, live pin otherwise
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wake_level_status <= '0;
        end else begin
            for (int w = 0; w < NUM_WK; w++) begin
                if (ch_armed[w]) begin
                    if (ch_vld[w]) begin
                        o_wake_level_status[w] <= ch_lvl[w];
                    end
                end else begin
                    o_wake_level_status[w] <= pin_s2_reg[w];
                end
            end
        end
    end

    // ==========================================================
    // Wake flags; a new event beats a clear in the same cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wake_flags <= '0;
        end else begin
            o_wake_flags <= ch_wake | (o_wake_flags & ~i_wake_flag_clr);
        end
    end

    // Cyclic wake timer events
    logic [1:0] tmr_evt;
    assign tmr_evt = i_timer_wake_en & t_start & ~t_first;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_timer_flags <= '0;
        end else begin
            o_timer_flags <= tmr_evt | (o_timer_flags & ~i_timer_flag_clr);
        end
    end

    // ==========================================================
    // Interrupt and wake requests to the mode controller
    // mode in, requests out
    logic awake_mode;
    logic sleep_mode;
    assign awake_mode = (i_mode == CSWT_MODE_NORMAL) || (i_mode == CSWT_MODE_STOP);
    assign sleep_mode = (i_mode == CSWT_MODE_SLEEP);

    // One-cycle pulses
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_int_req <= 1'b0;
        end else begin
            o_int_req <= awake_mode && ((|ch_wake) || (|tmr_evt));
        end
    end

    // Level request held while in Sleep with any wake flag pending, so a flag
    // left uncleared at Sleep entry wakes the device at once.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wake_req <= 1'b0;
        end else begin
            o_wake_req <= sleep_mode && ((|ch_wake) || (|o_wake_flags));
        end
    end

    // On-time longer than period is a configuration failure
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_spi_fail <= 1'b0;
        end else begin
            o_spi_fail <= (on_us(on_code[0]) > per_us(per_code[0])) ||
                          (on_us(on_code[1]) > per_us(per_code[1]));
        end
    end

endmodule : cswt_top

`default_nettype wire

// ==== dv/cswt_checker.sv ====
// Port checker for cswt_top.
// Assumes one clock domain; bound at the foot.
`default_nettype none
module cswt_checker
    import cswt_pkg::*;
(
    // Clock, reset, inputs
    input wire logic i_clk,
    input wire logic i_rst,
    input wire cswt_pkg::cswt_mode_t i_mode,
    input wire logic [3:0] i_hs_fault,
    input wire logic [2:0] i_first_timer_period,
    input wire logic [2:0] i_first_timer_on,
    input wire logic [2:0] i_wake_flag_clr,
    // Outputs
    input wire logic [3:0] o_high_side_driver,
    input wire logic [2:0] o_wake_flags,
    input wire logic [2:0] o_static_sense,
    input wire logic o_int_req,
    input wire logic o_wake_req,
    input wire logic o_spi_fail
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ==========================================================
    // Assertions
    AST_INT_PULSE: assert property (o_int_req |=> !o_int_req)
        else $error("int pulse too long");
    AST_INT_MODE: assert property (o_int_req |-> $past(i_mode) inside {CSWT_MODE_NORMAL, CSWT_MODE_STOP})
        else $error("int outside normal or stop");
    AST_STOP_INT: assert property ($rose(o_wake_flags[2]) && i_mode == CSWT_MODE_STOP |-> o_int_req)
        else $error("stop wake without int");
    AST_WAKE_MODE: assert property (o_wake_req |-> $past(i_mode) == CSWT_MODE_SLEEP)
        else $error("wake request outside sleep");
    AST_PENDING: assert property ((i_mode == CSWT_MODE_SLEEP && o_wake_flags != 3'h0)[*2] |-> o_wake_req)
        else $error("pending flag not waking");
    AST_STICKY: assert property (o_wake_flags[2] && !i_wake_flag_clr[2] |=> o_wake_flags[2])
        else $error("wake flag lost");
    AST_FSAFE: assert property ((i_mode == CSWT_MODE_FAILSAFE)[*3] |-> !o_high_side_driver && o_static_sense == 3'h7)
        else $error("fail-safe sensing not stopped");
    AST_FAULT: assert property ((i_hs_fault[0] && i_mode == CSWT_MODE_NORMAL)[*3] |-> !o_high_side_driver[0])
        else $error("faulted driver on");
    AST_SPI: assert property ((i_first_timer_period == 3'h0 && i_first_timer_on == 3'h5)[*2] |-> o_spi_fail)
        else $error("on-time over period not flagged");
endmodule // cswt_checker
bind cswt_top cswt_checker u_chk (.i_clk, .i_rst, .i_mode, .i_hs_fault, .i_first_timer_period,
    .i_first_timer_on, .i_wake_flag_clr, .o_high_side_driver, .o_wake_flags, .o_static_sense,
    .o_int_req, .o_wake_req, .o_spi_fail);
`default_nettype wire

// ==== dv/cswt_switch_net.sv ====
// Switch network: driver k feeds a switch onto wake pin k.
// Assumes ground-based pins with pull-down.
`default_nettype none
module cswt_switch_net (
    // Drivers and switches
    input wire logic [3:0] i_hs,
    input wire logic [2:0] i_closed,
    // Wake pins
    output logic [2:0] o_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pull-down wins while the driver is off, so no stale level survives
    assign o_pin = i_hs[2:0] & i_closed;
endmodule // cswt_switch_net
`default_nettype wire

// ==== dv/cswt_tb.sv ====
// Testbench for cswt_top with shortened time scales.
// Assumes the switch network model and bound checker.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import cswt_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    cswt_mode_t mode = CSWT_MODE_NORMAL;
    logic [3:0] fault = 4'h0;
    logic [2:0] per = 3'h0, on = ON_OFF_LOW, on2 = ON_OFF_LOW, wclr = 3'h0, sw = 3'h7, pin, flags, lvl, stat;
    logic [1:0] wen = 2'h0, tclr = 2'h0, tflg;
    logic [7:0] map = 8'h00;
    logic [5:0] ssel = 6'h00;
    logic [3:0] hs;
    logic irq, wreq, sfail;
    int error_cnt = 0;
    int tests_run = 0;
    int pms[7] = '{10, 20, 50, 100, 200, 1000, 2000};
    // ==========================================================
    // Clock, partner and design
    always #5 i_clk = ~i_clk;
    cswt_switch_net u_net (.i_hs(hs), .i_closed(sw), .o_pin(pin));
    cswt_top #(.PERIOD_SCALE(20000), .ON_SCALE(1), .FILT_CYCLES(2)) uut (.i_clk, .i_rst, .i_mode(mode),
        .i_hs_fault(fault), .i_first_timer_period(per), .i_first_timer_on(on), .i_second_timer_period(3'h1),
        .i_second_timer_on(on2), .i_timer_wake_en(wen), .i_high_side_map(map), .i_wake_sense_sel(ssel),
        .i_wake_flag_clr(wclr), .i_timer_flag_clr(tclr), .i_wake_input_pin(pin), .o_high_side_driver(hs),
        .o_wake_flags(flags), .o_timer_flags(tflg), .o_wake_level_status(lvl), .o_static_sense(stat),
        .o_int_req(irq), .o_wake_req(wreq), .o_spi_fail(sfail));
    // ==========================================================
    // Tasks
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Counts int pulses and cycles with driver 0 or 1 on
    task automatic run(input int cyc, output int ints, output int hon);
        ints = 0;
        hon = 0;
        repeat (cyc) begin
            @(negedge i_clk);
            ints += int'(irq === 1'b1);
            hon += int'(hs[1:0] !== 2'h0);
        end
    endtask
    task automatic report_and_stop;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Watchdog: the run needs about 70000 cycles
    initial begin
        #1000000;
        error_cnt++;
        report_and_stop();
    end
    // ==========================================================
    // Main sequence
    initial begin : main
        int a, b;
        repeat (2) @(negedge i_clk);
        i_rst = 1'b0;
        wen = 2'h1;
        for (int c = 0; c < 7; c++) begin
            per = 3'(c);
            on = ON_US_100_C;
            a = 0;
            do begin
                @(negedge i_clk);
                a++;
            end while (irq !== 1'b1 && a < 45000);
            chk("period", (a - pms[c] * 20) inside {[0:3]}, 1'b1);
            on = ON_OFF_LOW;
            @(negedge i_clk);
        end
        chk("timer flag", tflg[0], 1'b1);
        per = 3'h0;
        on = ON_US_20000_C;
        repeat (3) @(negedge i_clk);
        chk("spi fail", sfail, 1'b1);
        on = ON_OFF_LOW;
        wen = 2'h0;
        tclr = 2'h3;
        @(negedge i_clk);
        tclr = 2'h0;
        map = 8'h11;
        ssel = 6'h11;
        @(negedge i_clk);
        on = ON_US_100_C;
        mode = CSWT_MODE_STOP;
        run(400, a, b);
        chk("hs on", b, 200);
        chk("no wake", flags, 3'h0);
        sw = 3'h3;
        run(400, a, b);
        chk("flag", flags, 3'h4);
        chk("stop int", a, 1);
        chk("level", lvl, 3'h1);
        mode = CSWT_MODE_SLEEP;
        repeat (3) @(negedge i_clk);
        chk("pending", wreq, 1'b1);
        mode = CSWT_MODE_NORMAL;
        wclr = 3'h7;
        @(negedge i_clk);
        wclr = 3'h0;
        mode = CSWT_MODE_SLEEP;
        repeat (3) @(negedge i_clk);
        chk("no pending", wreq, 1'b0);
        sw = 3'h7;
        run(400, a, b);
        chk("sleep wake", wreq, 1'b1);
        chk("sleep ints", a, 0);
        mode = CSWT_MODE_NORMAL;
        wclr = 3'h7;
        ssel = 6'h10;
        wen = 2'h1;
        fault = 4'h1;
        // Fault latch takes one edge, the driver register the next
        @(negedge i_clk);
        run(400, a, b);
        wclr = 3'h0;
        chk("fault hs", b, 0);
        chk("timer runs", a, 2);
        mode = CSWT_MODE_FAILSAFE;
        repeat (4) @(negedge i_clk);
        chk("fs static", stat, 3'h7);
        mode = CSWT_MODE_NORMAL;
        on = ON_OFF_HIGH;
        repeat (3) @(negedge i_clk);
        chk("off high", hs[2], 1'b1);
        on = ON_OFF_LOW;
        repeat (3) @(negedge i_clk);
        chk("off low", hs[2], 1'b0);
        // second timer: source enabled, mapped, then timed (20 ms period, 0.1 ms on)
        wen = 2'h3;
        map = 8'h19;
        on2 = ON_US_100_C;
        run(400, a, b);
        chk("timer2 hs", b, 100);
        chk("timer2 first", tflg[1], 1'b0);
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
